// >>> asrf_pkg.sv
// Purpose: Shared constants of the audio serial register front end
// Assumes: Word-aligned byte offsets on a 6-bit register address
// Notes: Field positions and masks are used by the bank and its helpers
package asrf_pkg;
    // Register byte offsets
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_CLK0 = 6'h04;
    localparam logic [5:0] OFF_CLK1 = 6'h08;
    localparam logic [5:0] OFF_IEC = 6'h0C;
    localparam logic [5:0] OFF_IES = 6'h10;
    localparam logic [5:0] OFF_FLAG = 6'h14;
    localparam logic [5:0] OFF_SYNC = 6'h18;
    localparam logic [5:0] OFF_SER0 = 6'h20;
    localparam logic [5:0] OFF_SER1 = 6'h24;
    localparam logic [5:0] OFF_DAT0 = 6'h30;
    localparam logic [5:0] OFF_DAT1 = 6'h34;
    // One reserved word, watched by the read-zero check
    localparam logic [5:0] OFF_RSVD = 6'h1C;
    // Main control and sync-pending bit positions
    localparam int B_SOFT_RESET_BIT = 0;
    localparam int B_EN = 1;
    localparam int B_D0 = 8;
    localparam int B_D1 = 9;
    localparam int SYNC_W = 10;
    // Writable bits per register (everything else reads zero), then the sync bits a control write starts
    localparam logic [7:0] CTRL_MASK = 8'h3E;
    localparam logic [31:0] CLK_MASK = 32'hFFFD19FF;
    localparam logic [31:0] SER_MASK = 32'h07FFF7BF;
    localparam logic [15:0] IRQ_MASK = 16'h3333;
    localparam logic [SYNC_W-1:0] SYNC_CTRL_MASK = 10'h03E;
    localparam logic [SYNC_W-1:0] SYNC_SOFT_RESET_BIT_MASK = 10'h001;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [15:0] HALF_RESET = 16'h0000;
    // Interrupt flag positions of unit 0; unit 1 sits one bit higher
    localparam int IRQ_RXRDY = 0;
    localparam int IRQ_RXOR = 4;
    localparam int IRQ_TXRDY = 8;
    localparam int IRQ_TXUR = 12;
    // Cycles a synchronised operation counts down before its done cycle
    localparam logic [3:0] SYNC_CYCLES = 4'h3;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage

// >>> audio_serial_reg_front_end.sv
// What this block does
// - Registers are 8, 10, 16 or 32 bits wide
// - Byte and halfword lanes writable on their own
// - Enable-protected registers frozen while module enabled
// - Guard protection blocks control and configuration writes
// - Control and data writes pass a sync stage
// - Control bits 7:6 always read zero
// - Control bits 5:4 switch serializers 1 and 0
// - Control bits 3:2 switch clock units 1 and 0
// - Busy set at once; repeat while busy errors
// - Soft reset clears all but sync_pending, overrides other bits
// - Control bit 1 enables the whole module
// - Interrupt while flag and its enable set
//
// Purpose: Register bank of a two-unit audio serial controller
// Assumes: Word-aligned byte address with byte enables, one clock
// Notes: Sync latency is fixed; data reads are returned unsynchronised
`timescale 1ns/1ps
module audio_serial_reg_front_end
    import asrf_pkg::*;
(
    input wire logic i_clk, // System clock, 40 MHz
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes state when low
    input wire logic [5:0] i_addr, // Byte address, low two bits ignored
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_be, // Byte lane enables
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    input wire logic i_wr_protect, // Access guard protection level
    input wire logic [1:0] i_rx_has_word, // Receive ready events
    input wire logic [1:0] i_tx_needs_word, // Transmit ready events
    input wire logic [1:0] i_rx_overflow, // Receive overrun events
    input wire logic [1:0] i_tx_starved, // Transmit underrun events
    output logic [31:0] o_rdata, // Read data, cycle after strobe
    output logic o_bus_err, // Bus error, cycle after strobe
    output logic o_irq, // Combined interrupt level
    output logic o_module_on, // Global enable in effect
    output logic [1:0] o_clock_unit_on, // Clock unit enables
    output logic [1:0] o_serializer_on // Serializer enables
);
    sync_if sif();

    logic [7:0] ctrl_r;
    logic [7:0] pend_r;
    logic [31:0] clk_cfg_r [2];
    logic [31:0] ser_cfg_r [2];
    logic [31:0] data_r [2];
    logic [15:0] irq_en_r;
    logic [15:0] flags_r;
    logic [31:0] rdata_r;
    logic err_r;
    logic irq_r;
    logic [7:0] ev_sync;
    logic [15:0] ev_set;
    logic [SYNC_W-1:0] start_nxt;
    logic err_nxt;
    logic sreset;
    logic cfg_ok;
    logic ctrl_wr;
    logic [15:0] w1_bits;

    // Address match, shared by write and read decode
    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        hit = (a[5:2] == o[5:2]);
    endfunction

    // Lane merge so narrow accesses keep the other lanes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be,
                                          input logic [31:0] msk);
        logic [31:0] lane;
        lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = ((old & ~lane) | (wd & lane)) & msk;
    endfunction
    sync_tracker u_track (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .s(sif.trk)
    );
    sync2 #(.W(8)) u_ev (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_d({i_tx_starved, i_rx_overflow, i_tx_needs_word, i_rx_has_word}),
        .o_q(ev_sync)
    );

    // Event levels mapped onto the flag layout
    always_comb begin
        ev_set = HALF_RESET;
        ev_set[IRQ_RXRDY +: 2] = ev_sync[1:0];
        ev_set[IRQ_TXRDY +: 2] = ev_sync[3:2];
        ev_set[IRQ_RXOR +: 2] = ev_sync[5:4];
        ev_set[IRQ_TXUR +: 2] = ev_sync[7:6];
    end
    assign sreset = sif.done[B_SOFT_RESET_BIT];
    // Configs writable only when disabled and unguarded
    assign cfg_ok = !ctrl_r[B_EN] && !i_wr_protect;
    assign ctrl_wr = i_wr && hit(i_addr, OFF_CTRL) && i_be[0]
                     && !i_wr_protect;
    // Write-one lanes of the interrupt registers
    assign w1_bits = i_wdata[15:0] & {{8{i_be[1]}}, {8{i_be[0]}}} & IRQ_MASK;
    // Sync starts and bus errors for repeated pending operations
    always_comb begin
        start_nxt = '0;
        err_nxt = 1'b0;
        if (ctrl_wr) begin
            if (i_wdata[B_SOFT_RESET_BIT]) begin
                if (|(sif.busy & SYNC_SOFT_RESET_BIT_MASK)) begin
                    err_nxt = 1'b1;
                end else begin
                    start_nxt = SYNC_SOFT_RESET_BIT_MASK;
                end
            end else if (|(sif.busy & SYNC_CTRL_MASK)) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt = SYNC_CTRL_MASK;
            end
        end
        if (i_wr && hit(i_addr, OFF_DAT0) && |i_be) begin
            if (sif.busy[B_D0]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[B_D0] = 1'b1;
            end
        end
        if (i_wr && hit(i_addr, OFF_DAT1) && |i_be) begin
            if (sif.busy[B_D1]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[B_D1] = 1'b1;
            end
        end
    end
    assign sif.start = start_nxt;
    // Main control: written value held until its sync completes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_r <= CTRL_RESET;
            pend_r <= CTRL_RESET;
        end else if (i_ce) begin
            if (sreset) begin
                ctrl_r <= CTRL_RESET;
                pend_r <= CTRL_RESET;
            end else begin
                if (ctrl_wr && !i_wdata[B_SOFT_RESET_BIT] && !err_nxt) begin
                    pend_r <= i_wdata[7:0] & CTRL_MASK;
                end
                if (sif.done[B_EN]) begin
                    ctrl_r <= pend_r;
                end
            end
        end
    end

    // Clock-unit and serializer configs, lane by lane
    genvar u;
    generate
        for (u = 0; u < 2; u++) begin : g_unit
            localparam logic [5:0] OC = u ? OFF_CLK1 : OFF_CLK0;
            localparam logic [5:0] OS = u ? OFF_SER1 : OFF_SER0;
            localparam logic [5:0] OD = u ? OFF_DAT1 : OFF_DAT0;
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    clk_cfg_r[u] <= WORD_RESET;
                    ser_cfg_r[u] <= WORD_RESET;
                end else if (i_ce) begin
                    if (sreset) begin
                        clk_cfg_r[u] <= WORD_RESET;
                        ser_cfg_r[u] <= WORD_RESET;
                    end else if (i_wr && cfg_ok) begin
                        if (hit(i_addr, OC)) begin
                            clk_cfg_r[u] <= merge(clk_cfg_r[u], i_wdata,
                                                  i_be, CLK_MASK);
                        end
                        if (hit(i_addr, OS)) begin
                            ser_cfg_r[u] <= merge(ser_cfg_r[u], i_wdata,
                                                  i_be, SER_MASK);
                        end
                    end
                end
            end
            // Holding word; a write while pending is dropped
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    data_r[u] <= WORD_RESET;
                end else if (i_ce) begin
                    if (sreset) begin
                        data_r[u] <= WORD_RESET;
                    end else if (i_wr && hit(i_addr, OD)
                                 && sif.start[u ? B_D1 : B_D0]) begin
                        data_r[u] <= merge(data_r[u], i_wdata, i_be,
                                           32'hFFFFFFFF);
                    end
                end
            end
        end
    endgenerate

    // Interrupt enables; set and clear views share one store
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_en_r <= HALF_RESET;
        end else if (i_ce) begin
            if (sreset) begin
                irq_en_r <= HALF_RESET;
            end else if (i_wr && hit(i_addr, OFF_IES)) begin
                irq_en_r <= irq_en_r | w1_bits;
            end else if (i_wr && hit(i_addr, OFF_IEC)) begin
                irq_en_r <= irq_en_r & ~w1_bits;
            end
        end
    end

    // Sticky flags; a new event wins over a same-cycle clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flags_r <= HALF_RESET;
        end else if (i_ce) begin
            if (sreset) begin
                flags_r <= HALF_RESET;
            end else if (i_wr && hit(i_addr, OFF_FLAG)) begin
                flags_r <= (flags_r & ~w1_bits) | ev_set;
            end else begin
                flags_r <= flags_r | ev_set;
            end
        end
    end

    // Interrupt level, registered for a clean output
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_r <= 1'b0;
        end else if (i_ce) begin
            irq_r <= |(flags_r & irq_en_r);
        end
    end

    // Read mux; narrow registers sit in the low lanes
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r <= WORD_RESET;
            err_r <= 1'b0;
        end else if (i_ce) begin
            err_r <= err_nxt;
            rdata_r <= WORD_RESET;
            if (i_rd) begin
                if (hit(i_addr, OFF_CTRL)) begin
                    rdata_r <= {24'h000000, ctrl_r & CTRL_MASK};
                end else if (hit(i_addr, OFF_CLK0)) begin
                    rdata_r <= clk_cfg_r[0];
                end else if (hit(i_addr, OFF_CLK1)) begin
                    rdata_r <= clk_cfg_r[1];
                end else if (hit(i_addr, OFF_IEC) | hit(i_addr, OFF_IES)) begin
                    rdata_r <= {16'h0000, irq_en_r};
                end else if (hit(i_addr, OFF_FLAG)) begin
                    rdata_r <= {16'h0000, flags_r};
                end else if (hit(i_addr, OFF_SYNC)) begin
                    rdata_r <= {22'h0, sif.busy};
                end else if (hit(i_addr, OFF_SER0)) begin
                    rdata_r <= ser_cfg_r[0];
                end else if (hit(i_addr, OFF_SER1)) begin
                    rdata_r <= ser_cfg_r[1];
                end else if (hit(i_addr, OFF_DAT0)) begin
                    rdata_r <= data_r[0];
                end else if (hit(i_addr, OFF_DAT1)) begin
                    rdata_r <= data_r[1];
                end
            end
        end
    end

    assign o_rdata = rdata_r;
    assign o_bus_err = err_r;
    assign o_irq = irq_r;
    assign o_module_on = ctrl_r[B_EN];
    assign o_clock_unit_on = ctrl_r[3:2];
    assign o_serializer_on = ctrl_r[5:4];

    // Checks
    property p_ctrl_zero;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && i_rd && hit(i_addr, OFF_CTRL)) |=> (o_rdata[7:6] == 2'b00);
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("control reserved bits read nonzero");
    property p_unmapped;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && i_rd && hit(i_addr, OFF_RSVD)) |=> (o_rdata == WORD_RESET);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("reserved address read nonzero");
    property p_enprot;
        @(posedge i_clk) disable iff (!i_resetn)
        (ctrl_r[B_EN] && !sreset) |=> $stable(clk_cfg_r[0]);
    endproperty
    a_enprot: assert property (p_enprot)
        else $error("config changed while enabled");
    property p_wprot;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_wr_protect && !sreset) |=> $stable(ser_cfg_r[1]) && $stable(pend_r);
    endproperty
    a_wprot: assert property (p_wprot)
        else $error("protected write took effect");
    property p_busy_err;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && ctrl_wr && !i_wdata[B_SOFT_RESET_BIT] && sif.busy[B_EN]) |=> o_bus_err;
    endproperty
    a_busy_err: assert property (p_busy_err)
        else $error("missing bus error on busy write");
    property p_busy_set;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && ctrl_wr && !i_wdata[B_SOFT_RESET_BIT] && !err_nxt)
        |=> sif.busy[B_EN] ##1 sif.busy[B_EN];
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("sync pending not held");
    property p_apply;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && sif.done[B_EN] && !sreset) |=> (ctrl_r == $past(pend_r));
    endproperty
    a_apply: assert property (p_apply)
        else $error("control not applied after sync");
    property p_soft_reset_bit;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_ce && sreset) |=> (ctrl_r == CTRL_RESET && irq_en_r == HALF_RESET);
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit)
        else $error("soft reset left state");
    property p_irq;
        @(posedge i_clk) disable iff (!i_resetn)
        i_ce |=> (o_irq == |($past(flags_r) & $past(irq_en_r)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level mismatch");
endmodule

// >>> audio_serial_reg_front_end_bench.sv
// Purpose: Self-checking bench of the audio serial register front end
// Assumes: Bus tasks are entered 1 ns after a rising edge
// Notes: Sync latency is waited for by polling, save one fixed wait after the guarded control write
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        num_checks = num_checks + 1; \
        if ((got) !== (exp)) begin \
            $display("FAIL %s expected %0h seen %0h", nm, exp, got); \
            fail_count = fail_count + 1; \
        end \
    end
module audio_serial_reg_front_end_bench
    import asrf_pkg::*;
;
    typedef struct {
        logic [5:0] addr;
        logic [3:0] be;
        logic [31:0] wd;
        logic [31:0] exp;
    } row_t;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_ce = 1'b1;
    logic [5:0] i_addr = 6'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic [3:0] i_be = 4'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_wr_protect = 1'b0;
    logic [1:0] i_rx_has_word = 2'h0;
    logic [1:0] i_tx_needs_word = 2'h0;
    logic [1:0] i_rx_overflow = 2'h0;
    logic [1:0] i_tx_starved = 2'h0;
    logic [31:0] o_rdata;
    logic o_bus_err;
    logic o_irq;
    logic o_module_on;
    logic [1:0] o_clock_unit_on;
    logic [1:0] o_serializer_on;
    logic [31:0] rdat;
    logic berr;
    logic [5:0] outs;
    int fail_count = 0;
    int num_checks = 0;
    row_t rows [0:10];

    audio_serial_reg_front_end dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be),
        .i_wr(i_wr), .i_rd(i_rd), .i_wr_protect(i_wr_protect),
        .i_rx_has_word(i_rx_has_word),
        .i_tx_needs_word(i_tx_needs_word),
        .i_rx_overflow(i_rx_overflow), .i_tx_starved(i_tx_starved),
        .o_rdata(o_rdata), .o_bus_err(o_bus_err), .o_irq(o_irq),
        .o_module_on(o_module_on), .o_clock_unit_on(o_clock_unit_on),
        .o_serializer_on(o_serializer_on)
    );

    // All status outputs in one word for compact checks
    assign outs = {o_irq, o_module_on, o_clock_unit_on, o_serializer_on};

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    // Verdict and end of run, shared by the timeout
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One-cycle write; bus error captured in the answer cycle
    task automatic wr(input logic [5:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_be <= b;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1 berr = o_bus_err;
    endtask

    // One-cycle read; data taken only in the cycle after the strobe
    task automatic rd(input logic [5:0] a);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rdat = o_rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Poll until no synchronised operation is pending, bounded
    task automatic wait_idle();
        for (int k = 0; k < 20; k++) begin
            rd(OFF_SYNC);
            if (rdat[SYNC_W-1:0] === 10'h000) begin
                return;
            end
        end
        fail_count = fail_count + 1;
        $display("FAIL sync_pending never cleared");
        test_done();
    endtask

    // Guard against any hang
    initial begin
        #(25 * 20000);
        fail_count = fail_count + 1;
        $display("FAIL run limit reached");
        test_done();
    end

    initial begin
        // Plain accesses with module disabled: config writes allowed
        rows[0] = '{OFF_CLK0, 4'hF, 32'hFFFFFFFF, 32'hFFFD19FF};
        rows[1] = '{OFF_CLK1, 4'h2, 32'h0000AB00, 32'h00000900};
        rows[2] = '{OFF_CLK1, 4'hC, 32'h5A5A0000, 32'h5A580900};
        rows[3] = '{OFF_SER0, 4'hF, 32'hFFFFFFFF, 32'h07FFF7BF};
        rows[4] = '{OFF_SER1, 4'h3, 32'h0000FFFF, 32'h0000F7BF};
        rows[5] = '{OFF_DAT0, 4'hF, 32'h12345678, 32'h12345678};
        rows[6] = '{OFF_DAT1, 4'h1, 32'h000000A5, 32'h000000A5};
        rows[7] = '{6'h2C, 4'hF, 32'hFFFFFFFF, 32'h00000000};
        rows[8] = '{OFF_RSVD, 4'hF, 32'hFFFFFFFF, 32'h00000000};
        rows[9] = '{OFF_IES, 4'h3, 32'h0000FFFF, 32'h00003333};
        rows[10] = '{OFF_IEC, 4'h1, 32'h000000FF, 32'h00003300};
        repeat (10) @(posedge i_clk);
        `CHK("outputs in reset", 6'h00, outs);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        #1;
        rd(OFF_CTRL);
        `CHK("main_control reset", 32'h00000000, rdat);
        // Table of writes, each read back once sync has settled
        for (int i = 0; i <= 10; i++) begin
            wr(rows[i].addr, rows[i].be, rows[i].wd);
            wait_idle();
            rd(rows[i].addr);
            `CHK("table row", rows[i].exp, rdat);
        end
        // Enable all, then a repeat while busy must error out
        wr(OFF_CTRL, 4'h1, 32'h000000FE);
        `CHK("first ctrl err", 1'b0, berr);
        wr(OFF_CTRL, 4'h1, 32'h00000000);
        `CHK("busy ctrl err", 1'b1, berr);
        wait_idle();
        rd(OFF_CTRL);
        `CHK("ctrl reserved zero", 32'h0000003E, rdat);
        `CHK("module on", 1'b1, o_module_on);
        `CHK("clock units", 2'b11, o_clock_unit_on);
        `CHK("serializers", 2'b11, o_serializer_on);
        // Config frozen while enabled
        wr(OFF_CLK0, 4'hF, 32'h00000000);
        rd(OFF_CLK0);
        `CHK("clk0 frozen", 32'hFFFD19FF, rdat);
        wr(OFF_SER1, 4'hF, 32'h00000000);
        rd(OFF_SER1);
        `CHK("ser1 frozen", 32'h0000F7BF, rdat);
        // Guard protection drops a control write silently
        i_wr_protect <= 1'b1;
        wr(OFF_CTRL, 4'h1, 32'h00000002);
        `CHK("protect no err", 1'b0, berr);
        cyc(6);
        rd(OFF_CTRL);
        `CHK("ctrl protected", 32'h0000003E, rdat);
        i_wr_protect <= 1'b0;
        // Busy visible in the cycle right after the write
        wr(OFF_CTRL, 4'h1, 32'h00000012);
        rd(OFF_SYNC);
        `CHK("sync busy at once", 32'h0000003E, rdat);
        wait_idle();
        rd(OFF_CTRL);
        `CHK("ctrl partial", 32'h00000012, rdat);
        `CHK("clock units off", 2'b00, o_clock_unit_on);
        `CHK("serializer 0 only", 2'b01, o_serializer_on);
        // Every event source; table rows left other enables set
        wr(OFF_IES, 4'h1, 32'h00000001);
        i_rx_has_word <= 2'h3;
        i_tx_needs_word <= 2'h3;
        i_rx_overflow <= 2'h3;
        i_tx_starved <= 2'h3;
        cyc(8);
        rd(OFF_FLAG);
        `CHK("all flags", 32'h00003333, rdat);
        `CHK("irq raised", 1'b1, o_irq);
        wr(OFF_IEC, 4'h3, 32'h0000FFFF);
        cyc(3);
        `CHK("irq masked", 1'b0, o_irq);
        wr(OFF_IES, 4'h1, 32'h00000001);
        cyc(3);
        `CHK("irq again", 1'b1, o_irq);
        i_rx_has_word <= 2'h0;
        i_tx_needs_word <= 2'h0;
        i_rx_overflow <= 2'h0;
        i_tx_starved <= 2'h0;
        cyc(5);
        wr(OFF_FLAG, 4'h3, 32'h00000001);
        cyc(3);
        `CHK("irq cleared", 1'b0, o_irq);
        rd(OFF_FLAG);
        `CHK("flags left", 32'h00003332, rdat);
        // Soft reset wins over the other bits of its write
        wr(OFF_CTRL, 4'h1, 32'h0000003F);
        wait_idle();
        rd(OFF_CTRL);
        `CHK("soft_reset_bit ctrl", 32'h00000000, rdat);
        `CHK("soft_reset_bit outputs", 6'h00, outs);
        rd(OFF_CLK0);
        `CHK("soft_reset_bit clk0", 32'h00000000, rdat);
        rd(OFF_FLAG);
        `CHK("soft_reset_bit flags", 32'h00000000, rdat);
        rd(OFF_IES);
        `CHK("soft_reset_bit enables", 32'h00000000, rdat);
        // Hard reset in mid-run
        wr(OFF_CTRL, 4'h1, 32'h00000002);
        wait_idle();
        `CHK("on before reset", 1'b1, o_module_on);
        i_resetn <= 1'b0;
        cyc(3);
        `CHK("off in reset", 1'b0, o_module_on);
        i_resetn <= 1'b1;
        cyc(1);
        rd(OFF_CTRL);
        `CHK("ctrl after reset", 32'h00000000, rdat);
        // Clock enable low: the bank ignores the write entirely
        i_ce <= 1'b0;
        wr(OFF_CLK0, 4'hF, 32'hFFFFFFFF);
        i_ce <= 1'b1;
        rd(OFF_CLK0);
        `CHK("ce frozen", 32'h00000000, rdat);
        // Data write while its sync is pending errors and is dropped
        wr(OFF_DAT0, 4'hF, 32'h0000005A);
        wr(OFF_DAT0, 4'hF, 32'h000000A5);
        `CHK("data busy err", 1'b1, berr);
        wait_idle();
        rd(OFF_DAT0);
        `CHK("data kept", 32'h0000005A, rdat);
        test_done();
    end
endmodule

// >>> sync2.sv
// Purpose: Two-flop synchroniser for event pins
// Assumes: Inputs are levels from outside the clock domain
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 8
) (
    input wire logic i_clk, // System clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic [W-1:0] i_d, // Asynchronous levels
    output logic [W-1:0] o_q // Synchronised levels
);
    logic [W-1:0] meta_r;

    // Two stages; metastability settles in the first
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r <= '0;
            o_q <= '0;
        end else if (i_ce) begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

// >>> sync_if.sv
// Purpose: Start, pending and done lines of the sync tracker
// Assumes: One bit per synchronised operation
// Notes: Bit layout matches the sync_pending register
`timescale 1ns/1ps
interface sync_if;
    logic [9:0] start;
    logic [9:0] busy;
    logic [9:0] done;
    modport ctl (output start, input busy, input done);
    modport trk (input start, output busy, output done);
endinterface

// >>> sync_tracker.sv
// Purpose: Pending counters for synchronised operations
// Assumes: Start pulses are one cycle long
// Notes: Fixed latency stands in for the core-clock round trip
`timescale 1ns/1ps
module sync_tracker
    import asrf_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic i_ce, // Clock enable
    sync_if.trk s // Start in, busy and done out
);
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_op
            logic [3:0] cnt_r;
            logic done_r;
            // Busy from the edge after start through the done pulse
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    cnt_r <= CNT_ZERO;
                    done_r <= 1'b0;
                end else if (i_ce) begin
                    done_r <= (cnt_r == CNT_ONE);
                    if (s.start[g]) begin
                        cnt_r <= SYNC_CYCLES;
                    end else if (cnt_r != CNT_ZERO) begin
                        cnt_r <= cnt_r - CNT_ONE;
                    end
                end
            end
            // Registered only: start is decided from busy, so no loop
            assign s.busy[g] = (cnt_r != CNT_ZERO) | done_r;
            assign s.done[g] = done_r;
        end
    endgenerate
endmodule
